// *** ppts_regs.sv ***
/*
  Per-port timestamp register bank with asymmetry correction adjust.
  Assumes a single 100 MHz clock domain; capture strobes and correction
  requests come from datapath logic on the same clock. Register address
  bits [14:12] select the port (1..7), bits [11:0] the offset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ppts_consts.svh"

module ppts_regs #(
  parameter int NPORT = `PPTS_NUM_PORTS
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [14:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [NPORT-1:0] sync_egress_ts_cap,
  input wire logic [NPORT-1:0] dreq_ts_cap,
  input wire logic [NPORT-1:0] prsp_ts_cap,
  input wire logic [31:0] egress_ts_ns,
  input wire logic corr_valid,
  input wire logic [2:0] corr_port,
  input wire logic corr_is_ingress,
  input wire logic [63:0] corr_in,
  output logic corr_out_valid,
  output logic [63:0] corr_out,
  output logic [NPORT-1:0] port_ts_irq,
  output logic irq
);

  ppts_pkg::ppts_word_t rx_lat_ff [NPORT];
  ppts_pkg::ppts_word_t tx_lat_ff [NPORT];
  ppts_pkg::ppts_word_t asym_ff [NPORT];
  ppts_pkg::ppts_ts_t dreq_ts_ff [NPORT];
  ppts_pkg::ppts_ts_t sync_egress_ts_ff [NPORT];
  ppts_pkg::ppts_ts_t prsp_ts_ff [NPORT];
  ppts_pkg::ppts_flags_t flag_ff [NPORT];
  ppts_pkg::ppts_flags_t ien_ff [NPORT];
  ppts_pkg::ppts_word_t nxt_rx_lat [NPORT];
  ppts_pkg::ppts_word_t nxt_tx_lat [NPORT];
  ppts_pkg::ppts_word_t nxt_asym [NPORT];
  ppts_pkg::ppts_ts_t nxt_dreq_ts [NPORT];
  ppts_pkg::ppts_ts_t nxt_sync_egress_ts [NPORT];
  ppts_pkg::ppts_ts_t nxt_prsp_ts [NPORT];
  ppts_pkg::ppts_flags_t nxt_flag [NPORT];
  ppts_pkg::ppts_flags_t nxt_ien [NPORT];
  logic [15:0] rdata_ff, nxt_rdata;
  logic [NPORT-1:0] pirq_ff, nxt_pirq;
  logic irq_ff, nxt_irq;
  logic cvalid_ff, nxt_cvalid;
  logic [63:0] corr_ff, nxt_corr;

  // Port select from the upper address bits; 0 or out of range selects none
  function automatic logic port_hit(input logic [14:0] a, input int p);
    port_hit = (a[14:12] == 3'(p + `PPTS_FIRST_PORT));
  endfunction

  // Flag register word layout: sync 15, request 14, pdelay resp 13
  function automatic logic [15:0] flag_word(input ppts_pkg::ppts_flags_t f);
    flag_word = '0;
    flag_word[`PPTS_FLAG_SYNC_BIT] = f[2];
    flag_word[`PPTS_FLAG_DREQ_BIT] = f[1];
    flag_word[`PPTS_FLAG_PRSP_BIT] = f[0];
  endfunction

  function automatic ppts_pkg::ppts_flags_t word_flags(input logic [15:0] w);
    word_flags = {w[`PPTS_FLAG_SYNC_BIT], w[`PPTS_FLAG_DREQ_BIT],
      w[`PPTS_FLAG_PRSP_BIT]};
  endfunction

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      logic sel;
      logic wr;
      sel = port_hit(reg_addr, p);
      wr = reg_wr && sel;
      nxt_rx_lat[p] = rx_lat_ff[p];
      nxt_tx_lat[p] = tx_lat_ff[p];
      nxt_asym[p] = asym_ff[p];
      nxt_ien[p] = ien_ff[p];
      nxt_dreq_ts[p] = dreq_ts_ff[p];
      nxt_sync_egress_ts[p] = sync_egress_ts_ff[p];
      nxt_prsp_ts[p] = prsp_ts_ff[p];
      nxt_flag[p] = flag_ff[p];
      if (wr && reg_addr[11:0] == `PPTS_OFF_RX_LAT) begin
        nxt_rx_lat[p] = reg_wdata;
      end
      if (wr && reg_addr[11:0] == `PPTS_OFF_TX_LAT) begin
        nxt_tx_lat[p] = reg_wdata;
      end
      if (wr && reg_addr[11:0] == `PPTS_OFF_ASYM) begin
        nxt_asym[p] = reg_wdata;
      end
      if (wr && reg_addr[11:0] == `PPTS_OFF_IRQ_EN) begin
        nxt_ien[p] = word_flags(reg_wdata);
      end
      // Both halves load from one 32-bit sample in the same edge
      if (dreq_ts_cap[p]) begin
        nxt_dreq_ts[p] = egress_ts_ns;
      end
      if (sync_egress_ts_cap[p]) begin
        nxt_sync_egress_ts[p] = egress_ts_ns;
      end
      if (prsp_ts_cap[p]) begin
        nxt_prsp_ts[p] = egress_ts_ns;
      end
      // Clear first, then set: a capture in the clearing cycle survives
      if (wr && reg_addr[11:0] == `PPTS_OFF_FLAGS) begin
        nxt_flag[p] = nxt_flag[p] & ~word_flags(reg_wdata);
      end
      nxt_flag[p] = nxt_flag[p] | {sync_egress_ts_cap[p], dreq_ts_cap[p], prsp_ts_cap[p]};
    end
  end

  always_comb begin
    nxt_irq = 1'b0;
    for (int p = 0; p < NPORT; p++) begin
      nxt_pirq[p] = |(nxt_flag[p] & nxt_ien[p]);
      nxt_irq = nxt_irq | nxt_pirq[p];
    end
  end

  always_comb begin
    nxt_rdata = 16'h0000;
    if (reg_rd) begin
      for (int p = 0; p < NPORT; p++) begin
        if (port_hit(reg_addr, p)) begin
          unique case (reg_addr[11:0])
            `PPTS_OFF_RX_LAT: nxt_rdata = rx_lat_ff[p];
            `PPTS_OFF_TX_LAT: nxt_rdata = tx_lat_ff[p];
            `PPTS_OFF_ASYM: nxt_rdata = asym_ff[p];
            `PPTS_OFF_DREQ_HI: nxt_rdata = dreq_ts_ff[p][31:16];
            `PPTS_OFF_DREQ_LO: nxt_rdata = dreq_ts_ff[p][15:0];
            `PPTS_OFF_SYNC_HI: nxt_rdata = sync_egress_ts_ff[p][31:16];
            `PPTS_OFF_SYNC_LO: nxt_rdata = sync_egress_ts_ff[p][15:0];
            `PPTS_OFF_PRSP_HI: nxt_rdata = prsp_ts_ff[p][31:16];
            `PPTS_OFF_PRSP_LO: nxt_rdata = prsp_ts_ff[p][15:0];
            `PPTS_OFF_FLAGS: nxt_rdata = flag_word(flag_ff[p]);
            `PPTS_OFF_IRQ_EN: nxt_rdata = flag_word(ien_ff[p]);
            default: nxt_rdata = 16'h0000;
          endcase
        end
      end
    end
  end

  // Correction adjust: ingress adds, egress subtracts the signed value
  always_comb begin
    logic [63:0] mag;
    logic neg;
    logic [15:0] a;
    mag = '0;
    neg = 1'b0;
    a = 16'h0000;
    for (int p = 0; p < NPORT; p++) begin
      if (corr_port == 3'(p + `PPTS_FIRST_PORT)) begin
        a = asym_ff[p];
      end
    end
    mag = {49'h0, a[14:0]};
    neg = a[`PPTS_ASYM_SIGN_BIT] ^ ~corr_is_ingress;
    nxt_cvalid = corr_valid;
    nxt_corr = neg ? (corr_in - mag) : (corr_in + mag);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int p = 0; p < NPORT; p++) begin
        rx_lat_ff[p] <= `PPTS_RST_RX_LAT;
        tx_lat_ff[p] <= `PPTS_RST_TX_LAT;
        asym_ff[p] <= `PPTS_RST_ZERO;
        dreq_ts_ff[p] <= '0;
        sync_egress_ts_ff[p] <= '0;
        prsp_ts_ff[p] <= '0;
        flag_ff[p] <= '0;
        ien_ff[p] <= '0;
      end
      rdata_ff <= 16'h0000;
      pirq_ff <= '0;
      irq_ff <= 1'b0;
      cvalid_ff <= 1'b0;
      corr_ff <= 64'h0;
    end else begin
      rx_lat_ff <= nxt_rx_lat;
      tx_lat_ff <= nxt_tx_lat;
      asym_ff <= nxt_asym;
      dreq_ts_ff <= nxt_dreq_ts;
      sync_egress_ts_ff <= nxt_sync_egress_ts;
      prsp_ts_ff <= nxt_prsp_ts;
      flag_ff <= nxt_flag;
      ien_ff <= nxt_ien;
      rdata_ff <= nxt_rdata;
      pirq_ff <= nxt_pirq;
      irq_ff <= nxt_irq;
      cvalid_ff <= nxt_cvalid;
      corr_ff <= nxt_corr;
    end
  end

  assign reg_rdata = rdata_ff;
  assign port_ts_irq = pirq_ff;
  assign irq = irq_ff;
  assign corr_out_valid = cvalid_ff;
  assign corr_out = corr_ff;

  rx_reset_a: assert property (@(posedge ref_clk)
    $rose(rst_b) |-> rx_lat_ff[0] == 16'h019F && tx_lat_ff[0] == 16'h002D)
    else $error("latency reset values wrong");

  rd_after_wr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_wr && reg_addr[11:0] == 12'hC02 && reg_addr[14:12] != 3'h0
    ##1 reg_rd && reg_addr == $past(reg_addr)
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("tx latency readback wrong");

  asym_add_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    corr_valid && corr_is_ingress && corr_port == 3'h1 && !asym_ff[0][15]
    |=> corr_out == $past(corr_in) + {49'h0, $past(asym_ff[0][14:0])})
    else $error("ingress asymmetry add wrong");

  asym_sub_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    corr_valid && !corr_is_ingress && corr_port == 3'h1 && !asym_ff[0][15]
    |=> corr_out == $past(corr_in) - {49'h0, $past(asym_ff[0][14:0])})
    else $error("egress asymmetry subtract wrong");

  sign_flip_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    corr_valid && corr_is_ingress && corr_port == 3'h1 && asym_ff[0][15]
    |=> corr_out == $past(corr_in) - {49'h0, $past(asym_ff[0][14:0])})
    else $error("negative asymmetry not subtracted");

  ts_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sync_egress_ts_cap[0] |=> sync_egress_ts_ff[0] == $past(egress_ts_ns) && flag_ff[0][2])
    else $error("sync timestamp capture wrong");

  set_wins_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    dreq_ts_cap[0] && reg_wr && reg_addr == 15'h1C14 && reg_wdata[14] |=> flag_ff[0][1])
    else $error("flag set lost under clear");

  irq_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    port_ts_irq[0] == |(flag_ff[0] & ien_ff[0]))
    else $error("interrupt not gated by enable");

  rx_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_wr && reg_addr == 15'h1C00 |=> rx_lat_ff[0] == $past(reg_wdata))
    else $error("rx latency write lost");

  tx_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_wr && reg_addr == 15'h1C02 |=> tx_lat_ff[0] == $past(reg_wdata))
    else $error("tx latency write lost");

  asym_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_wr && reg_addr == 15'h1C04 |=> asym_ff[0] == $past(reg_wdata))
    else $error("asymmetry write lost");

  egress_neg_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    corr_valid && !corr_is_ingress && corr_port == 3'h1 && asym_ff[0][15]
    |=> corr_out == $past(corr_in) + {49'h0, $past(asym_ff[0][14:0])})
    else $error("negative egress asymmetry not added");

  corr_valid_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    1'b1 |=> corr_out_valid == $past(corr_valid))
    else $error("correction valid not one cycle later");

  dreq_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !dreq_ts_cap[0] |=> $stable(dreq_ts_ff[0]))
    else $error("request timestamp changed without capture");

  sync_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !sync_egress_ts_cap[0] |=> $stable(sync_egress_ts_ff[0]))
    else $error("sync timestamp changed without capture");

  prsp_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !prsp_ts_cap[0] |=> $stable(prsp_ts_ff[0]))
    else $error("pdelay resp timestamp changed without capture");

  dreq_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    dreq_ts_cap[0] |=> dreq_ts_ff[0] == $past(egress_ts_ns) && flag_ff[0][1])
    else $error("request timestamp capture wrong");

  prsp_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    prsp_ts_cap[0] |=> prsp_ts_ff[0] == $past(egress_ts_ns) && flag_ff[0][0])
    else $error("pdelay resp timestamp capture wrong");

  port7_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_wr && reg_addr == 15'h7C00 |=> rx_lat_ff[6] == $past(reg_wdata))
    else $error("last port latency write lost");

  port0_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_wr && reg_addr[14:12] == 3'h0 |=> $stable(rx_lat_ff[0]))
    else $error("port zero write reached a port");

  rd_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");

  flag_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_wr && reg_addr == 15'h1C14 && reg_wdata[15] && !sync_egress_ts_cap[0] |=> !flag_ff[0][2])
    else $error("sync flag not cleared by write one");

  flag_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_rd && reg_addr == 15'h1C14 |=> reg_rdata == {$past(flag_ff[0]), 13'h0000})
    else $error("flag word readback wrong");

  irq_or_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    irq == |port_ts_irq)
    else $error("interrupt not the OR of port interrupts");

  ien_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_wr && reg_addr == 15'h1C16
    |=> ien_ff[0] == {$past(reg_wdata[15]), $past(reg_wdata[14]), $past(reg_wdata[13])})
    else $error("enable write lost");

endmodule // ppts_regs
`default_nettype wire

// *** ppts_consts.svh ***
/*
  Offsets, field positions, reset values and sizes for the per-port
  timestamp register bank. Assumes a byte-addressed register port where
  each 16-bit register sits at an even offset inside a 4 KB port window.
*/
`ifndef PPTS_CONSTS_SVH
`define PPTS_CONSTS_SVH

`define PPTS_OFF_RX_LAT 12'hC00
`define PPTS_OFF_TX_LAT 12'hC02
`define PPTS_OFF_ASYM 12'hC04
`define PPTS_OFF_DREQ_HI 12'hC08
`define PPTS_OFF_DREQ_LO 12'hC0A
`define PPTS_OFF_SYNC_HI 12'hC0C
`define PPTS_OFF_SYNC_LO 12'hC0E
`define PPTS_OFF_PRSP_HI 12'hC10
`define PPTS_OFF_PRSP_LO 12'hC12
`define PPTS_OFF_FLAGS 12'hC14
`define PPTS_OFF_IRQ_EN 12'hC16

`define PPTS_RST_RX_LAT 16'h019F
`define PPTS_RST_TX_LAT 16'h002D
`define PPTS_RST_ZERO 16'h0000

`define PPTS_ASYM_SIGN_BIT 15
`define PPTS_FLAG_SYNC_BIT 15
`define PPTS_FLAG_DREQ_BIT 14
`define PPTS_FLAG_PRSP_BIT 13

`define PPTS_FIRST_PORT 1
`define PPTS_NUM_PORTS 7

`endif

// *** ppts_pkg.sv ***
/*
  Types shared by the per-port timestamp register bank.
  Assumes ppts_consts.svh for numeric constants.
*/
package ppts_pkg;
  typedef logic [15:0] ppts_word_t;
  typedef logic [31:0] ppts_ts_t;
  typedef logic [2:0] ppts_flags_t;
endpackage

// *** ppts_dp_model.sv ***
/*
  Datapath partner of the timestamp bank: capture pulses with a stamp,
  and correction requests. Assumes the bench calls its tasks in turn.
*/
`timescale 1ns/1ns
`default_nettype none
module ppts_dp_model (
  input wire logic ref_clk,
  output logic [6:0] sync_egress_ts_cap,
  output logic [6:0] dreq_ts_cap,
  output logic [6:0] prsp_ts_cap,
  output logic [31:0] egress_ts_ns,
  output logic corr_valid,
  output logic [2:0] corr_port,
  output logic corr_is_ingress,
  output logic [63:0] corr_in
);
  initial begin
    {sync_egress_ts_cap, dreq_ts_cap, prsp_ts_cap, egress_ts_ns} = '0;
    {corr_valid, corr_port, corr_is_ingress, corr_in} = '0;
  end
  // Kind 0 sync, 1 delay request, 2 pdelay response
  task automatic cap(input int kind, input int port, input logic [31:0] ts);
    logic [6:0] b;
    b = 7'h01 << (port - 1);
    @(posedge ref_clk);
    sync_egress_ts_cap <= (kind == 0) ? b : 7'h00;
    dreq_ts_cap <= (kind == 1) ? b : 7'h00;
    prsp_ts_cap <= (kind == 2) ? b : 7'h00;
    egress_ts_ns <= ts;
    @(posedge ref_clk);
    {sync_egress_ts_cap, dreq_ts_cap, prsp_ts_cap} <= '0;
    // Stale stamp inverted so a late sample cannot pass
    egress_ts_ns <= ~ts;
  endtask
  task automatic corr(input logic [2:0] port, input logic ing, input logic [63:0] cin);
    @(posedge ref_clk);
    {corr_valid, corr_port, corr_is_ingress, corr_in} <= {1'b1, port, ing, cin};
    @(posedge ref_clk);
    corr_valid <= 1'b0;
    corr_in <= ~cin;
  endtask
endmodule // ppts_dp_model
`default_nettype wire

// *** port_ptp_timestamp_regs_test.sv ***
/*
  Self-checking bench of the timestamp bank. Assumes ppts_regs with
  seven ports and the datapath partner ppts_dp_model.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module port_ptp_timestamp_regs_test;
  logic ref_clk, rst_b, reg_wr, reg_rd, rd_seen, corr_valid, corr_is_ingress;
  logic corr_out_valid, irq;
  logic [14:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, a, w, ev;
  logic [63:0] cev;
  logic [6:0] sync_egress_ts_cap, dreq_ts_cap, prsp_ts_cap, port_ts_irq;
  logic [31:0] egress_ts_ns;
  logic [2:0] corr_port;
  logic [63:0] corr_in, corr_out, cin, mag;
  logic [15:0] exp_q[$];
  logic [63:0] cexp_q[$];
  logic [15:0] d [8];
  logic [31:0] ts [3];
  logic [11:0] offs [11] = '{12'hC00, 12'hC02, 12'hC04, 12'hC08, 12'hC0A, 12'hC0C,
    12'hC0E, 12'hC10, 12'hC12, 12'hC14, 12'hC16};
  int n_fail, comparisons, seed;

  ppts_regs #(.NPORT(7)) DUT (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sync_egress_ts_cap(sync_egress_ts_cap), .dreq_ts_cap(dreq_ts_cap), .prsp_ts_cap(prsp_ts_cap),
    .egress_ts_ns(egress_ts_ns), .corr_valid(corr_valid), .corr_port(corr_port),
    .corr_is_ingress(corr_is_ingress), .corr_in(corr_in), .corr_out_valid(corr_out_valid),
    .corr_out(corr_out), .port_ts_irq(port_ts_irq), .irq(irq));
  ppts_dp_model dp (.ref_clk(ref_clk), .sync_egress_ts_cap(sync_egress_ts_cap),
    .dreq_ts_cap(dreq_ts_cap), .prsp_ts_cap(prsp_ts_cap), .egress_ts_ns(egress_ts_ns),
    .corr_valid(corr_valid), .corr_port(corr_port), .corr_is_ingress(corr_is_ingress),
    .corr_in(corr_in));

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Strobes left standing so bus cycles can run back to back
  task automatic op(input logic wv, rv, input int p, input logic [11:0] o,
      input logic [15:0] v);
    @(posedge ref_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {wv, rv, p[2:0], o, v};
    if (rv) exp_q.push_back(v);
  endtask
  task automatic wr(input int p, input logic [11:0] o, input logic [15:0] v);
    op(1'b1, 1'b0, p, o, v);
  endtask
  task automatic rd(input int p, input logic [11:0] o, input logic [15:0] v);
    op(1'b0, 1'b1, p, o, v);
  endtask
  task automatic settle();
    op(1'b0, 1'b0, 0, 12'h000, 16'h0000);
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #50000;
    n_fail++;
    finish_test();
  end
  always @(posedge ref_clk) begin
    if (rd_seen) begin
      ev = exp_q.pop_front();
      `CHK(reg_rdata, ev)
    end
    if (corr_out_valid === 1'b1) begin
      cev = cexp_q.pop_front();
      `CHK(corr_out, cev)
    end
    rd_seen <= reg_rd;
  end

  initial begin
    {seed, n_fail, comparisons, rd_seen, rst_b} = {32'd27, 64'd0, 2'b00};
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (offs[i]) begin
      w = (i == 0) ? 16'h019F : (i == 1) ? 16'h002D : 16'h0000;
      rd(1, offs[i], w);
      rd(7, offs[i], w);
    end
    rd(0, 12'hC00, 16'h0000);
    rd(2, 12'hC20, 16'h0000);
    settle();
    $display("reset values done");
    for (int p = 1; p <= 7; p++) begin
      d[p] = $random(seed);
      wr(p, 12'hC00, d[p]);
    end
    wr(4, 12'hC08, 16'hFFFF);
    for (int p = 1; p <= 7; p++) rd(p, 12'hC00, d[p]);
    rd(4, 12'hC08, 16'h0000);
    w = $random(seed);
    wr(2, 12'hC02, w);
    rd(2, 12'hC02, w);
    wr(2, 12'hC04, 16'h8001);
    rd(2, 12'hC04, 16'h8001);
    settle();
    $display("latency and asymmetry access done");
    for (int k = 0; k < 3; k++) begin
      ts[k] = $random(seed);
      dp.cap(k, 1, ts[k]);
    end
    rd(1, 12'hC0C, ts[0][31:16]);
    rd(1, 12'hC0E, ts[0][15:0]);
    rd(1, 12'hC08, ts[1][31:16]);
    rd(1, 12'hC0A, ts[1][15:0]);
    rd(1, 12'hC10, ts[2][31:16]);
    rd(1, 12'hC12, ts[2][15:0]);
    rd(1, 12'hC14, 16'hE000);
    rd(2, 12'hC14, 16'h0000);
    settle();
    `CHK(irq, 1'b0)
    wr(1, 12'hC16, 16'h4000);
    settle();
    `CHK(port_ts_irq, 7'h01)
    `CHK(irq, 1'b1)
    wr(1, 12'hC14, 16'h4000);
    settle();
    `CHK(irq, 1'b0)
    rd(1, 12'hC14, 16'hA000);
    settle();
    // Clear and capture of the same flag in one cycle: the set must win
    fork
      begin
        wr(1, 12'hC14, 16'h4000);
        settle();
      end
      dp.cap(1, 1, ts[0]);
    join
    `CHK(irq, 1'b1)
    rd(1, 12'hC14, 16'hE000);
    settle();
    $display("timestamp capture and flags done");
    for (int c = 0; c < 4; c++) begin
      a = $random(seed);
      a[15] = c[0];
      cin = {$random(seed), $random(seed)};
      wr(1, 12'hC04, a);
      settle();
      mag = {49'h0, a[14:0]};
      cexp_q.push_back((c[1] ^ a[15]) ? cin + mag : cin - mag);
      dp.corr(3'd1, c[1], cin);
    end
    settle();
    $display("correction adjust done");
    finish_test();
  end
endmodule // port_ptp_timestamp_regs_test
`default_nettype wire
